// [verilog/hbt_pkg.sv]
// Package for the holding brake test sequencer: constants, states and timing.
package hbt_pkg;
    // Telegram that carries the select bit and the selected report
    localparam int HBT_TELEGRAM = 701;
    // Brake output test interval in hours and clock rate
    localparam longint HBT_INTERVAL_H = 2160;
    localparam longint HBT_CLK_HZ = 100_000_000;
    localparam longint HBT_SEC_PER_H = 3600;
    localparam longint HBT_INTERVAL_CYC = HBT_INTERVAL_H * HBT_SEC_PER_H * HBT_CLK_HZ;
    // Speed limits in percent of maximum speed
    localparam int HBT_SEL_SPEED_PCT = 1;
    localparam int HBT_ACT_SPEED_PCT = 10;
    localparam int HBT_PCT_FULL = 100;
    // Default widths
    localparam int HBT_VAL_W = 16;
    localparam int HBT_POS_W = 32;
    localparam int HBT_TMR_W = 64;
    // Default length of the torque hold phase in cycles
    localparam int HBT_HOLD_CYC = 1000;
    // Level of the result bit
    localparam logic HBT_RESULT_PASS = 1'b1;
    localparam logic HBT_RESULT_FAIL = 1'b0;

    typedef enum logic [2:0] {
        HBT_IDLE, HBT_SELECTED, HBT_CLOSE, HBT_TORQUE, HBT_OPEN, HBT_DONE
    } hbt_state_t;
endpackage

// [verilog/hbt_link_if.sv]
// Interface carrying the cyclic control and info channels between both ends.
`timescale 1ns/1ps
interface hbt_link_if;
    // Safety control channel, controller to converter
    logic test_select;
    logic test_start;
    logic brake_sel;
    logic rot_dir;
    logic torque_dir;
    // Safety info channel, converter to controller
    logic test_selected;
    logic test_active;
    logic test_terminated;
    logic test_result;

    modport device (
        input test_select, test_start, brake_sel, rot_dir, torque_dir,
        output test_selected, test_active, test_terminated, test_result
    );
    modport ctrl (
        output test_select, test_start, brake_sel, rot_dir, torque_dir,
        input test_selected, test_active, test_terminated, test_result
    );
endinterface

// [verilog/hbt_ctrl.sv]
// Higher-level controller end: selects, starts and deselects the brake test.
`timescale 1ns/1ps
module hbt_ctrl
    import hbt_pkg::*;
(
    input wire logic sys_clk,            // System clock
    input wire logic rstn,               // Async reset, active low
    hbt_link_if.ctrl link,               // Cyclic channels to converter
    input wire logic run_req,            // Pulse: run one brake test
    input wire logic cond_brake,         // Brake to test
    input wire logic cond_rot_dir,       // Direction of rotation
    input wire logic cond_torque_dir,    // Torque direction
    input wire logic drive_ready,        // Motor on, brake open, encoder control
    input wire logic speed_low,          // Speed below 1 % of maximum
    output logic busy,                   // Test sequence in progress
    output logic done,                   // Pulse: test finished
    output logic passed                  // Result of last test
);
    typedef enum logic [1:0] {HC_IDLE, HC_SEL, HC_RUN, HC_DESEL} hbt_cstate_t;

    hbt_cstate_t st_r, st_nxt;
    logic sel_r, sel_nxt, start_r, start_nxt, pass_r, pass_nxt, done_r, done_nxt;
    logic br_r, br_nxt, rd_r, rd_nxt, td_r, td_nxt;

    always_comb begin
        st_nxt = st_r;
        sel_nxt = sel_r;
        start_nxt = start_r;
        pass_nxt = pass_r;
        done_nxt = 1'b0;
        br_nxt = br_r;
        rd_nxt = rd_r;
        td_nxt = td_r;
        unique case (st_r)
            HC_IDLE: begin
                if (run_req && drive_ready && speed_low) begin // see R10
                    sel_nxt = 1'b1; // see R1
                    br_nxt = cond_brake; // see R3
                    rd_nxt = cond_rot_dir;
                    td_nxt = cond_torque_dir;
                    st_nxt = HC_SEL;
                end
            end
            HC_SEL: begin
                if (link.test_selected) begin
                    start_nxt = 1'b1;
                    st_nxt = HC_RUN;
                end
            end
            HC_RUN: begin
                if (link.test_terminated) begin
                    pass_nxt = link.test_result;
                    sel_nxt = 1'b0; // see R9
                    start_nxt = 1'b0;
                    done_nxt = 1'b1;
                    st_nxt = HC_DESEL;
                end
            end
            HC_DESEL: begin
                if (!link.test_selected) begin
                    st_nxt = HC_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            st_r <= HC_IDLE;
            sel_r <= 1'b0;
            start_r <= 1'b0;
            pass_r <= 1'b0;
            done_r <= 1'b0;
            br_r <= 1'b0;
            rd_r <= 1'b0;
            td_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            sel_r <= sel_nxt;
            start_r <= start_nxt;
            pass_r <= pass_nxt;
            done_r <= done_nxt;
            br_r <= br_nxt;
            rd_r <= rd_nxt;
            td_r <= td_nxt;
        end
    end

    assign link.test_select = sel_r;
    assign link.test_start = start_r;
    assign link.brake_sel = br_r;
    assign link.rot_dir = rd_r;
    assign link.torque_dir = td_r;
    assign busy = (st_r != HC_IDLE);
    assign done = done_r;
    assign passed = pass_r;
endmodule

// [verilog/hbt_device.sv]
// Converter end: brake holding test sequence and brake output test timer.
`timescale 1ns/1ps
// Operation
// R1: Controller selects test by raising select bit
// R2: Device reports test selected on info channel
// R3: Controller supplies brake, rotation, torque direction
// R4: On start, assert active and close brake
// R5: Apply torque equal factor times base
// R6: Abort at once on position beyond tolerance
// R7: At end open brake, assert terminated
// R8: Result one is pass, zero is fail
// R9: Controller withdraws select after termination
// R10: Select needs ready, slow; active below ten percent
// R11: Output test timer, default 2160 h, readable
// R12: Timer expiry raises test-required message
// R13: Brake actuation clears message, reloads timer
// R14: Operator actuates brake within SIL period
// R15: Tolerance abort: brake open, terminated, fail
module hbt_device
    import hbt_pkg::*;
#(
    parameter int VAL_W = HBT_VAL_W,                 // Torque value width
    parameter int POS_W = HBT_POS_W,                 // Position width
    parameter int TMR_W = HBT_TMR_W,                 // Timer width
    parameter longint INTERVAL_CYC = HBT_INTERVAL_CYC, // Brake output test interval
    parameter int HOLD_CYC = HBT_HOLD_CYC            // Torque hold duration
) (
    input wire logic sys_clk,                  // System clock
    input wire logic rstn,                     // Async reset, active low
    hbt_link_if.device link,                   // Cyclic channels to controller
    input wire logic motor_on,                 // Motor switched on
    input wire logic encoder_ctrl,             // Speed control with encoder
    input wire logic brake_is_open,            // Brake feedback: open
    input wire logic [VAL_W-1:0] speed_abs,    // Absolute actual speed
    input wire logic [VAL_W-1:0] maximum_speed_setting, // Maximum speed
    input wire logic [VAL_W-1:0] test_torque_factor,    // Test torque factor
    input wire logic [VAL_W-1:0] test_torque_base,      // Base torque
    input wire logic [POS_W-1:0] test_position_tolerance, // Position tolerance
    input wire logic [POS_W-1:0] motor_pos,    // Actual motor position
    input wire logic op_brake_cmd,             // Operational brake close request
    output logic brake_close,                  // Brake close command
    output logic [2*VAL_W-1:0] torque_set,     // Torque setpoint magnitude
    output logic torque_neg,                   // Torque direction
    output logic test_brake_sel,               // Brake being tested
    output logic test_rot_dir,                 // Rotation direction in test
    output logic [TMR_W-1:0] brake_output_test_remaining, // Timer remaining
    output logic brake_output_test_required    // Brake output test required
);
    ////////////////////////////////////////////////////////////////////////
    // Speed checks, scaled to percent without a divider
    function automatic logic below_pct(input logic [VAL_W-1:0] spd,
                                       input logic [VAL_W-1:0] vmax,
                                       input int pct);
        logic [VAL_W+7:0] lhs;
        logic [VAL_W+7:0] rhs;
        lhs = (VAL_W+8)'(spd) * (VAL_W+8)'(HBT_PCT_FULL);
        rhs = (VAL_W+8)'(vmax) * (VAL_W+8)'(pct);
        return lhs < rhs;
    endfunction

    function automatic logic [POS_W-1:0] pos_dist(input logic [POS_W-1:0] a,
                                                  input logic [POS_W-1:0] b);
        return (a >= b) ? (a - b) : (b - a);
    endfunction

    logic sel_ok, act_ok, pos_bad;
    assign sel_ok = motor_on && encoder_ctrl && brake_is_open
                    && below_pct(speed_abs, maximum_speed_setting, HBT_SEL_SPEED_PCT);
    assign act_ok = below_pct(speed_abs, maximum_speed_setting, HBT_ACT_SPEED_PCT);

    ////////////////////////////////////////////////////////////////////////
    // Test sequencer
    hbt_state_t st_r, st_nxt;
    logic sel_prev_r, sel_prev_nxt;
    logic close_r, close_nxt, res_r, res_nxt;
    logic [2*VAL_W-1:0] trq_r, trq_nxt;
    logic tdir_r, tdir_nxt, bsel_r, bsel_nxt, rdir_r, rdir_nxt;
    logic [POS_W-1:0] pos0_r, pos0_nxt;
    logic [31:0] hold_r, hold_nxt;

    assign pos_bad = pos_dist(motor_pos, pos0_r) > test_position_tolerance;

    always_comb begin
        st_nxt = st_r;
        sel_prev_nxt = link.test_select;
        close_nxt = close_r;
        res_nxt = res_r;
        trq_nxt = trq_r;
        tdir_nxt = tdir_r;
        bsel_nxt = bsel_r;
        rdir_nxt = rdir_r;
        pos0_nxt = pos0_r;
        hold_nxt = hold_r;
        unique case (st_r)
            HBT_IDLE: begin
                // Rising select edge only; a held select does not retrigger
                if (link.test_select && !sel_prev_r && sel_ok) begin // see R1 see R10
                    st_nxt = HBT_SELECTED;
                end
            end
            HBT_SELECTED: begin
                if (!link.test_select) begin
                    st_nxt = HBT_IDLE;
                end else if (link.test_start) begin
                    bsel_nxt = link.brake_sel; // see R3
                    rdir_nxt = link.rot_dir;
                    tdir_nxt = link.torque_dir;
                    close_nxt = 1'b1; // see R4
                    pos0_nxt = motor_pos;
                    st_nxt = HBT_CLOSE;
                end
            end
            HBT_CLOSE: begin
                if (pos_bad || !act_ok) begin // see R6 see R10
                    res_nxt = HBT_RESULT_FAIL;
                    st_nxt = HBT_OPEN;
                end else if (!brake_is_open) begin
                    // Widen both operands so the full product is kept
                    trq_nxt = (2*VAL_W)'(test_torque_factor)
                              * (2*VAL_W)'(test_torque_base); // see R5
                    hold_nxt = '0;
                    st_nxt = HBT_TORQUE;
                end
            end
            HBT_TORQUE: begin
                hold_nxt = hold_r + 32'h1;
                if (pos_bad || !act_ok) begin // see R6 see R15
                    res_nxt = HBT_RESULT_FAIL;
                    trq_nxt = '0;
                    st_nxt = HBT_OPEN;
                end else if (hold_r >= 32'(HOLD_CYC - 1)) begin
                    res_nxt = HBT_RESULT_PASS; // see R8
                    trq_nxt = '0;
                    st_nxt = HBT_OPEN;
                end
            end
            HBT_OPEN: begin
                trq_nxt = '0;
                close_nxt = 1'b0; // see R7 see R15
                st_nxt = HBT_DONE;
            end
            HBT_DONE: begin
                if (!link.test_select) begin // see R9
                    st_nxt = HBT_IDLE;
                end
            end
            default: st_nxt = HBT_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            st_r <= HBT_IDLE;
            sel_prev_r <= 1'b0;
            close_r <= 1'b0;
            res_r <= HBT_RESULT_FAIL;
            trq_r <= '0;
            tdir_r <= 1'b0;
            bsel_r <= 1'b0;
            rdir_r <= 1'b0;
            pos0_r <= '0;
            hold_r <= '0;
        end else begin
            st_r <= st_nxt;
            sel_prev_r <= sel_prev_nxt;
            close_r <= close_nxt;
            res_r <= res_nxt;
            trq_r <= trq_nxt;
            tdir_r <= tdir_nxt;
            bsel_r <= bsel_nxt;
            rdir_r <= rdir_nxt;
            pos0_r <= pos0_nxt;
            hold_r <= hold_nxt;
        end
    end

    assign link.test_selected = (st_r != HBT_IDLE); // see R2
    assign link.test_active = (st_r == HBT_CLOSE) || (st_r == HBT_TORQUE); // see R4
    assign link.test_terminated = (st_r == HBT_DONE); // see R7
    assign link.test_result = res_r; // see R8

    ////////////////////////////////////////////////////////////////////////
    // Brake output test timer
    logic brake_cmd, brake_cmd_prev_r, actuated;
    logic [TMR_W-1:0] tmr_r, tmr_nxt;
    logic req_r, req_nxt;

    // Test closure and the operational request are ORed; either one closes the brake
    assign brake_cmd = close_r || op_brake_cmd;
    assign actuated = brake_cmd != brake_cmd_prev_r;

    always_comb begin
        tmr_nxt = tmr_r;
        req_nxt = req_r;
        if (actuated) begin
            // Actuation wins over expiry in the same cycle
            tmr_nxt = TMR_W'(INTERVAL_CYC); // see R13
            req_nxt = 1'b0;
        end else if (tmr_r != '0) begin
            tmr_nxt = tmr_r - TMR_W'(1); // see R11
        end else begin
            req_nxt = 1'b1; // see R12
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            tmr_r <= TMR_W'(INTERVAL_CYC);
            req_r <= 1'b0;
            brake_cmd_prev_r <= 1'b0;
        end else begin
            tmr_r <= tmr_nxt;
            req_r <= req_nxt;
            brake_cmd_prev_r <= brake_cmd;
        end
    end

    assign brake_close = brake_cmd;
    assign torque_set = trq_r;
    assign torque_neg = tdir_r;
    assign test_brake_sel = bsel_r;
    assign test_rot_dir = rdir_r;
    assign brake_output_test_remaining = tmr_r;
    assign brake_output_test_required = req_r;
endmodule

// [bench/hbt_link_sva.sv]
// Checker for the link between the brake test controller and converter ends.
`timescale 1ns/1ps
module hbt_link_sva #(
    parameter longint INTERVAL_CYC = 50 // Reload value of the output test timer
) (
    input wire logic sys_clk, // System clock
    input wire logic rstn, // Async reset, active low
    input wire logic test_select, // Select bit
    input wire logic test_start, // Start bit
    input wire logic test_selected, // Selected report
    input wire logic test_active, // Test active report
    input wire logic test_terminated, // Test terminated report
    input wire logic test_result, // Result bit
    input wire logic brake_close, // Brake close command
    input wire logic [63:0] brake_output_test_remaining, // Timer remaining
    input wire logic brake_output_test_required // Output test required
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);

    a_sel_after_req: assert property ($rose(test_selected) |-> $past(test_select))
        else $error("selected report without select");
    a_start_gated: assert property ($rose(test_active)
        |-> $past(test_start) && $past(test_selected))
        else $error("test went active without start");
    a_active_brake: assert property (test_active |-> brake_close)
        else $error("brake open while test active");
    a_end_order: assert property ($fell(test_active) |=> test_terminated)
        else $error("no terminated report after test end");
    a_term_holds: assert property (test_terminated && test_select |=> test_terminated)
        else $error("terminated dropped while still selected");
    a_term_excl: assert property (test_terminated |-> !test_active)
        else $error("terminated and active together");
    a_result_steady: assert property (test_terminated ##1 test_terminated
        |-> $stable(test_result))
        else $error("result changed after termination");
    a_timer_reload: assert property (brake_close != $past(brake_close)
        |=> brake_output_test_remaining == INTERVAL_CYC && !brake_output_test_required)
        else $error("timer not reloaded on actuation");
    // Actuation is judged against the previous cycle, so expiry needs a steady command now
    a_timer_expire: assert property (brake_output_test_remaining == '0
        && $stable(brake_close) |=> brake_output_test_required)
        else $error("expired timer raised no message");
endmodule

// [bench/holding_brake_test_sequencer_tb_top.sv]
// Testbench joining controller and converter ends of the brake test link.
`timescale 1ns/1ps
module holding_brake_test_sequencer_tb_top;
    import hbt_pkg::*;
    localparam longint IVL = 50;
    logic sys_clk = 1'b0;
    logic rstn = 1'b0;
    logic run_req = 1'b0;
    logic cond_brake = 1'b0;
    logic cond_rot_dir = 1'b0;
    logic cond_torque_dir = 1'b0;
    logic ready = 1'b1;
    logic motor_on = 1'b1;
    logic brake_is_open = 1'b1;
    logic op_brake_cmd = 1'b0;
    logic [15:0] speed_abs = 16'h0005;
    logic [15:0] vmax = 16'h03E8;
    logic [31:0] motor_pos = 32'h000003E8;
    wire logic busy, done, passed, brake_close, torque_neg, brake_sel, rot_dir, required;
    wire logic [31:0] torque_set;
    wire logic [63:0] remaining;
    int error_cnt = 0;
    int n_compared = 0;

    hbt_link_if link ();
    hbt_ctrl i_hbt_ctrl (.sys_clk(sys_clk), .rstn(rstn), .link(link), .run_req(run_req),
        .cond_brake(cond_brake), .cond_rot_dir(cond_rot_dir), .cond_torque_dir(cond_torque_dir),
        .drive_ready(ready), .speed_low(ready), .busy(busy), .done(done), .passed(passed));
    hbt_device #(.INTERVAL_CYC(IVL), .HOLD_CYC(8)) i_hbt_device (.sys_clk(sys_clk), .rstn(rstn),
        .link(link), .motor_on(motor_on), .encoder_ctrl(ready), .brake_is_open(brake_is_open),
        .speed_abs(speed_abs), .maximum_speed_setting(vmax), .test_torque_factor(16'h0003),
        .test_torque_base(16'h0007), .test_position_tolerance(32'h0000000A),
        .motor_pos(motor_pos), .op_brake_cmd(op_brake_cmd), .brake_close(brake_close),
        .torque_set(torque_set), .torque_neg(torque_neg), .test_brake_sel(brake_sel),
        .test_rot_dir(rot_dir), .brake_output_test_remaining(remaining),
        .brake_output_test_required(required));
    hbt_link_sva #(.INTERVAL_CYC(IVL)) i_hbt_link_sva (.sys_clk(sys_clk), .rstn(rstn),
        .test_select(link.test_select), .test_start(link.test_start),
        .test_selected(link.test_selected), .test_active(link.test_active),
        .test_terminated(link.test_terminated), .test_result(link.test_result),
        .brake_close(brake_close), .brake_output_test_remaining(remaining),
        .brake_output_test_required(required));

    initial begin
        forever #5 sys_clk = ~sys_clk;
    end

    // Brake feedback lags the command by one cycle, like a slow mechanism
    always @(posedge sys_clk) begin
        brake_is_open <= !brake_close;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        n_compared++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    task automatic end_of_test;
        $display("compared %0d, mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // Called at a clock edge; reset spans eight rising edges
    task automatic do_reset;
        rstn <= 1'b0;
        repeat (7) @(posedge sys_clk);
        #1 check(remaining, IVL);
        check(required, 0);
        @(posedge sys_clk);
        rstn <= 1'b1;
    endtask

    // Timer runs out, then one brake actuation reloads it
    task automatic timer_test;
        repeat (IVL + 5) @(posedge sys_clk);
        #1 check(required, 1);
        @(posedge sys_clk);
        op_brake_cmd <= 1'b1;
        @(posedge sys_clk);
        #1 check(remaining, IVL);
        check(required, 0);
        @(posedge sys_clk);
        op_brake_cmd <= 1'b0;
    endtask

    // Kind 0 passes, 1 aborts on position, 2 aborts on speed while active
    task automatic run_test(input int kind);
        int i;
        @(posedge sys_clk);
        run_req <= 1'b1;
        cond_brake <= 1'b1;
        cond_rot_dir <= kind[1];
        cond_torque_dir <= kind[0];
        @(posedge sys_clk);
        run_req <= 1'b0;
        for (i = 0; i < 50 && link.test_active !== 1'b1; i++) @(posedge sys_clk);
        #1 check(brake_close, 1);
        check({brake_sel, rot_dir, torque_neg}, {1'b1, kind[1], kind[0]});
        if (kind == 0) begin
            for (i = 0; i < 20 && torque_set === 32'h0; i++) @(posedge sys_clk);
            #1 check(torque_set, 32'h00000015);
        end else if (kind == 1) begin
            @(posedge sys_clk);
            motor_pos <= 32'h000003F3;
        end else begin
            @(posedge sys_clk);
            speed_abs <= 16'h0064;
        end
        for (i = 0; i < 100 && done !== 1'b1; i++) begin
            @(posedge sys_clk);
            #1;
        end
        check(link.test_terminated, 1);
        check(brake_close, 0);
        check(link.test_result, kind == 0);
        check(passed, kind == 0);
        @(posedge sys_clk);
        motor_pos <= 32'h000003E8;
        speed_abs <= 16'h0005;
        for (i = 0; i < 50 && busy !== 1'b0; i++) @(posedge sys_clk);
        #1 check(busy, 1'b0);
    endtask

    // Speed of two percent at selection must be refused
    task automatic refuse_test;
        @(posedge sys_clk);
        speed_abs <= 16'h0014;
        run_req <= 1'b1;
        @(posedge sys_clk);
        run_req <= 1'b0;
        repeat (20) @(posedge sys_clk);
        #1 check(link.test_selected, 0);
        @(posedge sys_clk);
        speed_abs <= 16'h0005;
        // The controller end waits for a selected report that never comes
        do_reset;
    endtask

    initial begin
        do_reset;
        timer_test;
        run_test(0);
        run_test(1);
        run_test(2);
        refuse_test;
        run_test(0);
        end_of_test;
    end

    initial begin
        repeat (5000) @(posedge sys_clk);
        error_cnt++;
        end_of_test;
    end
endmodule
